// *** rtl/feature_id_consts.svh ***
// constants for the build_param_a feature identification readout
`ifndef FEATURE_ID_CONSTS_SVH
`define FEATURE_ID_CONSTS_SVH
`define CRC_LSB        16
`define SHA2_LSB       12
`define SHA1_LSB       8
`define AES_LSB        4
`define SHA3_LSB       32
`define SM3_LSB        36
`define SM4_LSB        40
`define CRC_CODE       4'h1
`define SHA2_CODE      4'h2
`define SHA1_CODE      4'h1
`define AES_CODE       4'h2
`define SM_SHA3_CODE   4'h1
`define ABSENT_CODE    4'h0
`define TRAP_CLASS     6'h18
`endif

// *** rtl/feature_id_pkg.sv ***
// types for the build_param_a feature identification readout
package feature_id_pkg;
  typedef enum logic [1:0] {
    priv_level_0,
    priv_level_1,
    priv_level_2,
    priv_level_3
  } priv_level_t;

  typedef struct packed {
    logic        valid;
    priv_level_t current_privilege_level;
    logic        level2_enabled;
    logic        hyp_route_all_exceptions;
    logic        hyp_trap_feature_id;
  } read_req_t;

  typedef struct packed {
    logic        done;
    logic        trap;
    priv_level_t target_level;
    logic [5:0]  trap_class;
    logic [63:0] data;
  } read_resp_t;

  typedef struct packed {
    logic       strap_done;
    logic       build_param_a_on;
    read_resp_t resp;
  } readout_state_t;
endpackage

// *** rtl/feature_id_access.sv ***
// privilege check for reads of the feature register
`timescale 1ns/100ps
`include "feature_id_consts.svh"
module feature_id_access
  import feature_id_pkg::*;
(
  input  wire read_req_t   req_in,
  output logic             trap_out,
  output priv_level_t      target_out
);
  always_comb begin
    trap_out   = 1'b0;
    target_out = priv_level_1;
    case (req_in.current_privilege_level)
      priv_level_0: begin
        trap_out = 1'b1; // [RL7]
        if (req_in.level2_enabled && req_in.hyp_route_all_exceptions) begin
          target_out = priv_level_2; // [RL7]
        end
      end
      priv_level_1: begin
        if (req_in.level2_enabled && req_in.hyp_trap_feature_id) begin
          trap_out   = 1'b1; // [RL8]
          target_out = priv_level_2;
        end
      end
      default: begin
        trap_out = 1'b0; // [RL9]
      end
    endcase
  end
endmodule // feature_id_access

// *** rtl/build_param_a_feature_id_readout.sv ***
// build_param_a feature identification register with privilege trapping
// Behaviour
// RL1: checksum field bits 19:16 always reads 0b0001.
// RL2: build_param_a present only if build parameter set and disable low at reset.
// RL3: bits 15:12 read 0b0010 when build_param_a enabled, else zero.
// RL4: bits 11:8 read 0b0001 when build_param_a enabled, else zero.
// RL5: bits 7:4 read zero when build_param_a absent or disabled.
// RL6: bits 7:4 read 0b0010 when build_param_a present and enabled.
// RL7: level 0 reads trap, class 0x18, to level 2 if routed else 1.
// RL8: level 1 reads trap to level 2 when enabled and trap bit set.
// RL9: level 2 and 3 reads always return the register.
// RL10: SM3, SM4 and SHA-3 fields read 0b0001 when build_param_a enabled, else zero.
// RL11: register is read-only; bits 3:0 always read zero.
`timescale 1ns/100ps
`include "feature_id_consts.svh"
module build_param_a_feature_id_readout
  import feature_id_pkg::*;
#(
  parameter bit build_param_a = 1'b1
)(
  input  wire logic       clk_in,
  input  wire logic       reset_n_in,
  input  wire logic       build_param_a_disable_in,
  input  wire read_req_t  req_in,
  output read_resp_t      resp_out,
  output logic            build_param_a_on_out
);
  ////////////////////////////////////////////////////////////////////////////
  readout_state_t state_reg;
  readout_state_t state_next;
  logic           build_param_a_now;
  logic           trap;
  logic           take_trap;
  priv_level_t    target;
  logic [63:0]    value;

  feature_id_access access_u (
    .req_in     (req_in),
    .trap_out   (trap),
    .target_out (target)
  );

  // value assembled from build_param_a_now only: the live strap on the strap edge, the captured state after it
  function automatic logic [63:0] build_value(input logic on);
    logic [63:0] v;
    v = 64'h0; // [RL11]
    v[`CRC_LSB +: 4] = `CRC_CODE; // [RL1]
    if (on) begin
      v[`SHA2_LSB +: 4] = `SHA2_CODE; // [RL3]
      v[`SHA1_LSB +: 4] = `SHA1_CODE; // [RL4]
      v[`AES_LSB +: 4]  = `AES_CODE; // [RL6]
      v[`SHA3_LSB +: 4] = `SM_SHA3_CODE; // [RL10]
      v[`SM3_LSB +: 4]  = `SM_SHA3_CODE;
      v[`SM4_LSB +: 4]  = `SM_SHA3_CODE;
    end else begin
      v[`AES_LSB +: 4]  = `ABSENT_CODE; // [RL5]
    end
    return v;
  endfunction

  // strap is taken live on the first edge after reset, then held for good
  always_comb begin
    if (state_reg.strap_done) begin
      build_param_a_now = state_reg.build_param_a_on; // [RL11]
    end else begin
      build_param_a_now = build_param_a && !build_param_a_disable_in; // [RL2]
    end
  end
  // a read taken on the strap edge sees the live strap value that is being captured on that same edge
  assign value     = build_value(build_param_a_now);
  assign take_trap = req_in.valid && trap;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    state_next                   = state_reg;
    state_next.strap_done        = 1'b1;
    state_next.build_param_a_on         = build_param_a_now; // [RL2] [RL11]
    state_next.resp.done         = req_in.valid;
    state_next.resp.trap         = take_trap; // [RL7] [RL8] [RL9]
    state_next.resp.target_level = take_trap ? target : priv_level_1;
    state_next.resp.trap_class   = take_trap ? `TRAP_CLASS : 6'h00; // [RL7] [RL8]
    state_next.resp.data         = (req_in.valid && !trap) ? value : 64'h0;
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign resp_out      = state_reg.resp;
  assign build_param_a_on_out = state_reg.build_param_a_on;

  ////////////////////////////////////////////////////////////////////////////
  // register image fields
  crc_field_a: assert property (@(posedge clk_in) disable iff (!reset_n_in) // [RL1]
    state_reg.resp.done && !state_reg.resp.trap |-> state_reg.resp.data[19:16] == 4'h1)
    else $error("checksum field wrong");

  sha2_field_a: assert property (@(posedge clk_in) disable iff (!reset_n_in) // [RL3]
    state_reg.resp.done && !state_reg.resp.trap
      |-> state_reg.resp.data[15:12] == (state_reg.build_param_a_on ? 4'h2 : 4'h0))
    else $error("sha2 field wrong");

  sha1_field_a: assert property (@(posedge clk_in) disable iff (!reset_n_in) // [RL4]
    state_reg.resp.done && !state_reg.resp.trap
      |-> state_reg.resp.data[11:8] == (state_reg.build_param_a_on ? 4'h1 : 4'h0))
    else $error("sha1 field wrong");

  aes_off_a: assert property (@(posedge clk_in) disable iff (!reset_n_in) // [RL5]
    state_reg.resp.done && !state_reg.resp.trap && !state_reg.build_param_a_on
      |-> state_reg.resp.data[7:4] == 4'h0)
    else $error("aes field not zero");

  aes_on_a: assert property (@(posedge clk_in) disable iff (!reset_n_in) // [RL6]
    state_reg.resp.done && !state_reg.resp.trap && state_reg.build_param_a_on
      |-> state_reg.resp.data[7:4] == 4'h2)
    else $error("aes field wrong");

  sm_sha3_a: assert property (@(posedge clk_in) disable iff (!reset_n_in) // [RL10]
    state_reg.resp.done && !state_reg.resp.trap
      |-> state_reg.resp.data[43:32] == (state_reg.build_param_a_on ? 12'h111 : 12'h000))
    else $error("sm3 sm4 sha3 fields wrong");

  for (genvar i = 0; i < 3; i++) begin : g_sm_field
    sm_nibble_a: assert property (@(posedge clk_in) disable iff (!reset_n_in) // [RL10]
      state_reg.resp.done && !state_reg.resp.trap
        |-> state_reg.resp.data[`SHA3_LSB + 4 * i +: 4]
          == (state_reg.build_param_a_on ? `SM_SHA3_CODE : `ABSENT_CODE))
      else $error("sm or sha3 field wrong");
  end

  upper_zero_a: assert property (@(posedge clk_in) disable iff (!reset_n_in) // [RL11]
    state_reg.resp.done && !state_reg.resp.trap
      |-> state_reg.resp.data[63:44] == 20'h0 && state_reg.resp.data[31:20] == 12'h0)
    else $error("fields outside this block not zero");

  ////////////////////////////////////////////////////////////////////////////
  // privilege trapping
  level0_trap_a: assert property (@(posedge clk_in) disable iff (!reset_n_in) // [RL7]
    req_in.valid && req_in.current_privilege_level == priv_level_0 |=> state_reg.resp.trap
      && state_reg.resp.trap_class == 6'h18
      && state_reg.resp.target_level == (($past(req_in.level2_enabled)
         && $past(req_in.hyp_route_all_exceptions)) ? priv_level_2 : priv_level_1))
    else $error("level 0 trap wrong");

  level1_trap_a: assert property (@(posedge clk_in) disable iff (!reset_n_in) // [RL8]
    req_in.valid && req_in.current_privilege_level == priv_level_1
      |=> state_reg.resp.trap == ($past(req_in.level2_enabled)
          && $past(req_in.hyp_trap_feature_id)))
    else $error("level 1 trap wrong");

  level1_pass_a: assert property (@(posedge clk_in) disable iff (!reset_n_in) // [RL8]
    req_in.valid && req_in.current_privilege_level == priv_level_1
      && !(req_in.level2_enabled && req_in.hyp_trap_feature_id)
      |=> state_reg.resp.done && !state_reg.resp.trap)
    else $error("level 1 read trapped");

  level1_target_a: assert property (@(posedge clk_in) disable iff (!reset_n_in) // [RL8]
    req_in.valid && req_in.current_privilege_level == priv_level_1
      && req_in.level2_enabled && req_in.hyp_trap_feature_id
      |=> state_reg.resp.target_level == priv_level_2 && state_reg.resp.trap_class == 6'h18)
    else $error("level 1 trap target wrong");

  high_level_a: assert property (@(posedge clk_in) disable iff (!reset_n_in) // [RL9]
    req_in.valid && req_in.current_privilege_level[1] |=> !state_reg.resp.trap
      && state_reg.resp.done)
    else $error("high level read trapped");

  trap_target_a: assert property (@(posedge clk_in) disable iff (!reset_n_in) // [RL7]
    state_reg.resp.trap |-> state_reg.resp.target_level inside {priv_level_1, priv_level_2})
    else $error("trap target level wrong");

  l2_target_a: assert property (@(posedge clk_in) disable iff (!reset_n_in) // [RL7]
    state_reg.resp.trap && state_reg.resp.target_level == priv_level_2
      |-> $past(req_in.level2_enabled))
    else $error("trap to level 2 while disabled");

  trap_origin_a: assert property (@(posedge clk_in) disable iff (!reset_n_in) // [RL9]
    state_reg.resp.trap
      |-> $past(req_in.current_privilege_level) inside {priv_level_0, priv_level_1})
    else $error("trap from level 2 or 3");

  ////////////////////////////////////////////////////////////////////////////
  // response framing
  read_answer_a: assert property (@(posedge clk_in) disable iff (!reset_n_in) // [RL9]
    req_in.valid |=> state_reg.resp.done)
    else $error("read not answered");

  idle_quiet_a: assert property (@(posedge clk_in) disable iff (!reset_n_in) // [RL9]
    !req_in.valid |=> !state_reg.resp.done && !state_reg.resp.trap
      && state_reg.resp.trap_class == 6'h00 && state_reg.resp.data == 64'h0)
    else $error("response without read");

  trap_data_a: assert property (@(posedge clk_in) disable iff (!reset_n_in) // [RL7]
    state_reg.resp.trap |-> state_reg.resp.done && state_reg.resp.data == 64'h0
      && state_reg.resp.trap_class == 6'h18)
    else $error("trap response wrong");

  pass_fields_a: assert property (@(posedge clk_in) disable iff (!reset_n_in) // [RL9]
    state_reg.resp.done && !state_reg.resp.trap
      |-> state_reg.resp.trap_class == 6'h00 && state_reg.resp.target_level == priv_level_1)
    else $error("untrapped read carries trap fields");

  class_gate_a: assert property (@(posedge clk_in) disable iff (!reset_n_in) // [RL8]
    state_reg.resp.trap_class != 6'h00 |-> state_reg.resp.trap)
    else $error("trap class without trap");

  ////////////////////////////////////////////////////////////////////////////
  // strap and read-only
  build_param_a_strap_a: assert property (@(posedge clk_in) disable iff (!reset_n_in) // [RL2]
    $rose(state_reg.strap_done) |-> state_reg.build_param_a_on == (build_param_a && !$past(build_param_a_disable_in)))
    else $error("build_param_a strap not captured");

  build_off_a: assert property (@(posedge clk_in) disable iff (!reset_n_in) // [RL2]
    !build_param_a |-> !state_reg.build_param_a_on)
    else $error("build_param_a on without build support");

  read_only_a: assert property (@(posedge clk_in) disable iff (!reset_n_in) // [RL11]
    state_reg.strap_done && $past(state_reg.strap_done) |-> $stable(state_reg.build_param_a_on)
      && (!state_reg.resp.done || state_reg.resp.data[3:0] == 4'h0))
    else $error("register not read-only");
endmodule // build_param_a_feature_id_readout

// *** tb/pipe_model.sv ***
// pipeline model that issues feature register reads
`timescale 1ns/100ps
module pipe_model
  import feature_id_pkg::*;
(
  input  wire logic      clk_in,
  input  wire read_req_t cmd_in,
  output read_req_t      req_out
);
  // one read per cycle, launched on the rising edge
  initial req_out = '0;
  always @(posedge clk_in) begin
    req_out <= cmd_in;
  end
endmodule // pipe_model

// *** tb/build_param_a_feature_id_readout_tb.sv ***
// testbench for the build_param_a feature identification readout
`timescale 1ns/100ps
module build_param_a_feature_id_readout_tb
  import feature_id_pkg::*;
;
  logic       clk_in;
  logic       reset_n_in;
  logic       build_param_a_disable_in;
  read_req_t  cmd;
  read_req_t  req;
  read_resp_t resp_a;
  read_resp_t resp_b;
  logic       on_a;
  logic       on_b;
  int         err_count;
  int         num_checks;
  ////////////////////////////////////////////////////////////////////////////
  pipe_model u_pipe_model (.clk_in(clk_in), .cmd_in(cmd), .req_out(req));
  build_param_a_feature_id_readout u_build_param_a_feature_id_readout (.clk_in(clk_in),
    .reset_n_in(reset_n_in), .build_param_a_disable_in(build_param_a_disable_in), .req_in(req),
    .resp_out(resp_a), .build_param_a_on_out(on_a));
  // build without build_param_a shares the same read stream
  build_param_a_feature_id_readout #(.build_param_a(1'b0)) u_build_param_a_feature_id_readout_off (
    .clk_in(clk_in), .reset_n_in(reset_n_in), .build_param_a_disable_in(build_param_a_disable_in),
    .req_in(req), .resp_out(resp_b), .build_param_a_on_out(on_b));
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [63:0] value(input logic on);
    value = {20'h0, {3{on ? 4'h1 : 4'h0}}, 12'h0, 4'h1,
             on ? 12'h212 : 12'h000, 4'h0};
  endfunction
  task automatic stop_test();
    if (err_count == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
    num_checks++;
    if (g !== e) begin
      $display("[ERR] %s expected %h seen %h", n, e, g);
      err_count++;
    end
  endtask
  task automatic rst(input logic dis);
    reset_n_in = 1'b0;
    build_param_a_disable_in = dis;
    repeat (20) @(posedge clk_in);
    #1 reset_n_in = 1'b1;
    repeat (2) @(posedge clk_in);
    #1 chk("build_param_a_on", !dis, on_a);
    chk("build_param_a_on_off", 1'b0, on_b);
  endtask
  task automatic rd(input priv_level_t l, input logic e, r, t);
    cmd = '{1'b1, l, e, r, t};
    @(posedge clk_in);
    #1 cmd.valid = 1'b0;
    @(posedge clk_in);
    #1 chk("done", 1'b1, resp_a.done);
  endtask
  task automatic trapchk(input priv_level_t l, input logic e, r, t, et,
                         input priv_level_t etl);
    rd(l, e, r, t);
    chk("trap", et, resp_a.trap);
    chk("target", etl, resp_a.target_level);
    chk("class", et ? 6'h18 : 6'h00, resp_a.trap_class);
    chk("data", et ? 64'h0 : value(1'b1), resp_a.data);
    @(posedge clk_in);
    #1 chk("done_end", 1'b0, resp_a.done);
    chk("class_end", 6'h00, resp_a.trap_class);
  endtask
  task automatic fields(input logic dis);
    rst(dis);
    rd(priv_level_3, 1'b1, 1'b1, 1'b1);
    chk("data_l3", value(!dis), resp_a.data);
    chk("data_off", value(1'b0), resp_b.data);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end
  initial begin
    #100000 err_count++;
    stop_test();
  end
  initial begin
    err_count = 0;
    num_checks = 0;
    cmd = '0;
    fields(1'b0);
    trapchk(priv_level_0, 1'b1, 1'b1, 1'b0, 1'b1, priv_level_2);
    trapchk(priv_level_0, 1'b0, 1'b1, 1'b0, 1'b1, priv_level_1);
    trapchk(priv_level_0, 1'b1, 1'b0, 1'b1, 1'b1, priv_level_1);
    trapchk(priv_level_1, 1'b1, 1'b0, 1'b1, 1'b1, priv_level_2);
    trapchk(priv_level_1, 1'b1, 1'b1, 1'b0, 1'b0, priv_level_1);
    trapchk(priv_level_1, 1'b0, 1'b0, 1'b1, 1'b0, priv_level_1);
    trapchk(priv_level_2, 1'b1, 1'b1, 1'b1, 1'b0, priv_level_1);
    fields(1'b1);
    stop_test();
  end
endmodule // build_param_a_feature_id_readout_tb
